// ---- rtl/spc_pkg.sv ----
// Constants shared by the speech command, power and analog control block.
// Assumes a 50 MHz system clock; all cycle counts are derived from it here.
package spc_pkg;

   localparam int unsigned CLK_KHZ = 50000;

   // Times in their own units.
   localparam int unsigned PROC_US = 10;
   localparam int unsigned OSC_STAB_US = 5000;
   localparam int unsigned UP_NOPOP_MS = 35;
   localparam int unsigned DN_NOPOP_MS = 110;
   localparam int unsigned UP_POP_MS = 90;
   localparam int unsigned DN_POP_MS = 140;

   // Cycle counts derived from the times.
   localparam logic [23:0] PROC_CYC = 24'(PROC_US * CLK_KHZ / 1000);
   localparam logic [23:0] OSC_CYC = 24'(OSC_STAB_US * CLK_KHZ / 1000);
   localparam logic [23:0] UP_NOPOP_CYC = 24'(UP_NOPOP_MS * CLK_KHZ);
   localparam logic [23:0] DN_NOPOP_CYC = 24'(DN_NOPOP_MS * CLK_KHZ);
   localparam logic [23:0] UP_POP_CYC = 24'(UP_POP_MS * CLK_KHZ);
   localparam logic [23:0] DN_POP_CYC = 24'(DN_POP_MS * CLK_KHZ);

   // Opcodes, compared on the upper bits shown.
   localparam logic [6:0] OPC_PWR_UP = 7'h00;
   localparam logic [5:0] OPC_ANALOG = 6'h01;
   localparam logic [7:0] OPC_AVOL = 8'h08;
   localparam logic [7:0] OPC_FADE = 8'h0c;
   localparam logic [7:0] OPC_PWR_DOWN = 8'h20;
   localparam logic [3:0] OPC_PHRASE = 4'h3;
   localparam logic [3:0] OPC_PLAY = 4'h4;
   localparam logic [3:0] OPC_STOP = 4'h6;
   localparam logic [3:0] OPC_SILENCE = 4'h7;
   localparam logic [3:0] OPC_RPT_SET = 4'h8;
   localparam logic [3:0] OPC_RPT_CLR = 4'h9;
   localparam logic [3:0] OPC_CH_VOL = 4'ha;
   localparam logic [6:0] OPC_STAT_RD = 7'h58;
   localparam logic [4:0] OPC_STAT_PIN = 5'h18;
   localparam logic [7:0] OPC_SAFE = 8'hd0;
   localparam logic [7:0] OPC_ERR_CLR = 8'hff;

   // Field positions in the analog setup second byte and in the status pin byte.
   localparam int unsigned DAG_POS = 5;
   localparam int unsigned AIG_POS = 3;
   localparam int unsigned DAC_POWER_ENABLE_POS = 2;
   localparam int unsigned SPEAKER_POWER_ENABLE_POS = 1;
   localparam int unsigned POP_POS = 0;
   localparam int unsigned STAT_SEL_POS = 2;

   // Reset values.
   localparam logic [1:0] HPF_RST = 2'h0;
   localparam logic [1:0] DAG_RST = 2'h2;
   localparam logic [1:0] AIG_RST = 2'h0;
   localparam logic [4:0] VOL_RST = 5'h00;

   typedef enum logic [2:0] {ST_PD, ST_OSC, ST_IDLE, ST_PROC, ST_RAMP} spc_state_e;

endpackage : spc_pkg

// ---- rtl/spc_ctrl.sv ----
// Command decoder for the power, analog setup and channel housekeeping
// commands of a four channel speech playback device.
// Assumes a host that clocks bytes MSB first on cmd_sclk rising edges and only
// while cmd_busy_n is high; playback logic on sys_clk supplies channel status.
`timescale 1ns/1ps

// Function
// - Silence opcode with mask; second byte is silence length for masked channels.
// - Repeat set/clear per mask; a stop on a channel also clears its repeat.
// - Channel volume opcode with mask; second byte low five bits give level.
// - Status read shifts out channel or fail-safe status; bit zero picks errors.
// - Status pin shows busy or accept-ready of the indexed channel.
// - Fail-safe second byte loads monitor time, thermal and supply settings.
// - All-ones byte clears latched fail-safe errors.
// - In power-down only power-up is acted on; other bytes are dropped.
// - Power-down at power-on, reset pin low, or after power-down command.
// - Power-up bit zero enables double entry; commands need matching repeats.
// - After power-up wait for oscillator; reset pin low forces power-down.
// - Power-up leaves line and speaker outputs off.
// - Analog setup: filter in first byte, gains and enables in second.
// - Power-down with analog up ramps down using power-up pop setting.
// - Filter select: off, 200 Hz, 300 Hz, 400 Hz.
// - Without pop suppression, analog up after 35 ms, down after 110 ms.
// - With pop suppression, ramp up takes 90 ms, down 140 ms.
// - Gain codes: off, -6 dB, 0 dB; DAC gain resets to 0 dB.
// - Speaker enable powers DAC and speaker; else DAC enable drives line out.
// - Entering power-down returns every setting to its initial value.
module spc_ctrl #(
   parameter logic [23:0] OSC_CYC = spc_pkg::OSC_CYC,
   parameter logic [23:0] UP_NOPOP_CYC = spc_pkg::UP_NOPOP_CYC,
   parameter logic [23:0] DN_NOPOP_CYC = spc_pkg::DN_NOPOP_CYC,
   parameter logic [23:0] UP_POP_CYC = spc_pkg::UP_POP_CYC,
   parameter logic [23:0] DN_POP_CYC = spc_pkg::DN_POP_CYC
) (
   // System clock and reset
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic reset_in_n,
   // Serial command link
   input wire logic cmd_sclk,
   input wire logic cmd_sel_n,
   input wire logic cmd_sdi,
   output logic cmd_sdo,
   output logic cmd_busy_n,
   // Channel status from playback logic
   input wire logic [3:0] ch_busy,
   input wire logic [3:0] channel_accept_ready,
   input wire logic [2:0] fault_in,
   // Power and analog section
   output logic power_down,
   output logic [1:0] highpass_sel,
   output logic [1:0] dac_gain,
   output logic [1:0] analog_in_gain,
   output logic dac_power_enable,
   output logic speaker_power_enable,
   output logic pop_suppress,
   output logic analog_up,
   output logic dac_on,
   output logic speaker_on,
   output logic line_out_on,
   // Channel settings
   output logic [3:0] repeat_en,
   output logic [19:0] ch_volume_level,
   output logic [7:0] silence_length,
   output logic [3:0] silence_load,
   // Fail-safe and status
   output logic [2:0] monitor_time_sel,
   output logic [1:0] thermal_detect_sel,
   output logic [2:0] supply_detect_sel,
   output logic [2:0] fault_latched,
   output logic error_clear,
   output logic status_pin
);

   // Link domain.
   logic link_clr;
   logic [2:0] bit_cnt_q;
   logic [7:0] rx_sh_q;
   logic [7:0] rx_byte_q;
   logic byte_tgl_q;
   logic [7:0] tx_sh_q;
   logic [7:0] stat_word_q;

   assign link_clr = reset | cmd_sel_n;

   always_ff @(posedge cmd_sclk or posedge link_clr)
   begin
      if (link_clr)
      begin
         bit_cnt_q <= 3'h0;
         rx_sh_q <= 8'h00;
      end
      else
      begin
         bit_cnt_q <= bit_cnt_q + 3'h1;
         rx_sh_q <= {rx_sh_q[6:0], cmd_sdi};
      end
   end

   // The byte register is held until the next byte; the host waits on busy.
   always_ff @(posedge cmd_sclk or posedge reset)
   begin
      if (reset)
      begin
         rx_byte_q <= 8'h00;
         byte_tgl_q <= 1'b0;
      end
      else if (!cmd_sel_n && bit_cnt_q == 3'h7)
      begin
         rx_byte_q <= {rx_sh_q[6:0], cmd_sdi};
         byte_tgl_q <= ~byte_tgl_q;
      end
   end

   // Status word is frozen in the system domain while busy is high, so it is
   // stable whenever the host is allowed to clock the read byte.
   always_ff @(negedge cmd_sclk or posedge link_clr)
   begin
      if (link_clr)
         tx_sh_q <= 8'h00;
      else if (bit_cnt_q == 3'h0)
         tx_sh_q <= stat_word_q;
      else
         tx_sh_q <= {tx_sh_q[6:0], 1'b0};
   end

   assign cmd_sdo = tx_sh_q[7];

   // Crossings into the system domain.
   logic tgl_s1_q, tgl_s2_q, tgl_s3_q, tgl_seen_q;
   logic rst_s1_q, rst_s2_q, rst_s3_q, rst_lvl_q;
   logic byte_ev;
   logic pin_low;

   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         tgl_s1_q <= 1'b0;
         tgl_s2_q <= 1'b0;
         tgl_s3_q <= 1'b0;
         tgl_seen_q <= 1'b0;
      end
      else
      begin
         tgl_s1_q <= byte_tgl_q;
         tgl_s2_q <= tgl_s1_q;
         tgl_s3_q <= tgl_s2_q;
         if (tgl_s2_q == tgl_s3_q)
            tgl_seen_q <= tgl_s3_q;
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         rst_s1_q <= 1'b0;
         rst_s2_q <= 1'b0;
         rst_s3_q <= 1'b0;
         rst_lvl_q <= 1'b0;
      end
      else
      begin
         rst_s1_q <= reset_in_n;
         rst_s2_q <= rst_s1_q;
         rst_s3_q <= rst_s2_q;
         if (rst_s2_q == rst_s3_q)
            rst_lvl_q <= rst_s3_q;
      end
   end

   assign byte_ev = (tgl_s2_q == tgl_s3_q) && (tgl_s3_q != tgl_seen_q);
   assign pin_low = !rst_lvl_q;

   // Sequencing.
   spc_pkg::spc_state_e st_q, st_d;
   logic [23:0] cnt_q;
   logic [23:0] ramp_cyc_q;
   logic ramp_req_q, ramp_tgt_q, pd_req_q;
   logic ana_on_q;
   logic dbl_q, de_have_q, rd_slot_q;
   logic [7:0] de_byte_q;
   logic [0:0] first_have_q;
   logic [7:0] first_q;
   logic status_sel_busy_q;
   logic [1:0] status_idx_q;
   logic acc, is_pup, init;
   logic [7:0] cmd;

   assign cmd = rx_byte_q;
   assign is_pup = cmd[7:1] == spc_pkg::OPC_PWR_UP;
   assign acc = byte_ev && (st_q == spc_pkg::ST_IDLE || st_q == spc_pkg::ST_PD)
                && !rd_slot_q && (!dbl_q || (de_have_q && de_byte_q == cmd));

   always_comb
   begin
      st_d = st_q;
      case (st_q)
         spc_pkg::ST_PD:
            if (acc && is_pup)
               st_d = spc_pkg::ST_OSC;
         spc_pkg::ST_OSC:
            if (cnt_q == 24'h000000)
               st_d = spc_pkg::ST_IDLE;
         spc_pkg::ST_IDLE:
            if (acc)
               st_d = spc_pkg::ST_PROC;
         spc_pkg::ST_PROC:
            if (cnt_q == 24'h000000)
            begin
               if (ramp_req_q)
                  st_d = spc_pkg::ST_RAMP;
               else if (pd_req_q)
                  st_d = spc_pkg::ST_PD;
               else
                  st_d = spc_pkg::ST_IDLE;
            end
         spc_pkg::ST_RAMP:
            if (cnt_q == 24'h000000)
               st_d = pd_req_q ? spc_pkg::ST_PD : spc_pkg::ST_IDLE;
         default:
            st_d = spc_pkg::ST_PD;
      endcase
      if (reset || pin_low)
         st_d = spc_pkg::ST_PD;
   end

   assign init = reset || pin_low || (st_q != spc_pkg::ST_PD && st_d == spc_pkg::ST_PD);

   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         st_q <= spc_pkg::ST_PD;
         cnt_q <= 24'h000000;
      end
      else
      begin
         st_q <= st_d;
         if (st_d != st_q)
         begin
            case (st_d)
               spc_pkg::ST_OSC: cnt_q <= OSC_CYC - 24'h000001;
               spc_pkg::ST_PROC: cnt_q <= spc_pkg::PROC_CYC - 24'h000001;
               spc_pkg::ST_RAMP: cnt_q <= ramp_cyc_q - 24'h000001;
               default: cnt_q <= 24'h000000;
            endcase
         end
         else if (cnt_q != 24'h000000)
            cnt_q <= cnt_q - 24'h000001;
      end
   end

   // Busy falls with each accepted byte and rises when that byte's processing and any ramp are done.
   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         cmd_busy_n <= 1'b1;
         power_down <= 1'b1;
      end
      else
      begin
         cmd_busy_n <= st_d == spc_pkg::ST_IDLE || st_d == spc_pkg::ST_PD;
         power_down <= st_d == spc_pkg::ST_PD;
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (init)
         ana_on_q <= 1'b0;
      else if (st_q == spc_pkg::ST_RAMP && cnt_q == 24'h000000)
         ana_on_q <= ramp_tgt_q;
   end

   // Double entry: the first copy is held, the second must match it.
   always_ff @(posedge sys_clk)
   begin
      if (init)
      begin
         de_have_q <= 1'b0;
         de_byte_q <= 8'h00;
         rd_slot_q <= 1'b0;
      end
      else if (byte_ev && st_q == spc_pkg::ST_IDLE)
      begin
         if (rd_slot_q)
            rd_slot_q <= 1'b0;
         else if (dbl_q && !de_have_q)
         begin
            de_have_q <= 1'b1;
            de_byte_q <= cmd;
         end
         else
         begin
            de_have_q <= 1'b0;
            if (acc && !(|first_have_q) && cmd[7:1] == spc_pkg::OPC_STAT_RD)
               rd_slot_q <= 1'b1;
         end
      end
   end

   // Decoder and settings.
   logic dec;
   logic pop_at_up_q;
   logic [3:0] msk;
   logic new_on;

   assign dec = acc && st_q == spc_pkg::ST_IDLE;
   assign msk = first_have_q[0] ? first_q[3:0] : cmd[3:0];
   assign new_on = cmd[spc_pkg::DAC_POWER_ENABLE_POS] | cmd[spc_pkg::SPEAKER_POWER_ENABLE_POS];

   function automatic logic two_byte(input logic [7:0] b);
      two_byte = b[7:2] == spc_pkg::OPC_ANALOG || b == spc_pkg::OPC_AVOL
                 || b == spc_pkg::OPC_FADE || b[7:4] == spc_pkg::OPC_PHRASE
                 || b[7:4] == spc_pkg::OPC_PLAY || b[7:4] == spc_pkg::OPC_SILENCE
                 || b[7:4] == spc_pkg::OPC_CH_VOL || b == spc_pkg::OPC_SAFE;
   endfunction : two_byte

   always_ff @(posedge sys_clk)
   begin
      silence_load <= 4'h0;
      error_clear <= 1'b0;
      if (init || (acc && st_q == spc_pkg::ST_PD && is_pup))
      begin
         dbl_q <= (!init) & cmd[0];
         first_have_q <= 1'b0;
         first_q <= 8'h00;
         highpass_sel <= spc_pkg::HPF_RST;
         dac_gain <= spc_pkg::DAG_RST;
         analog_in_gain <= spc_pkg::AIG_RST;
         dac_power_enable <= 1'b0;
         speaker_power_enable <= 1'b0;
         pop_suppress <= 1'b0;
         pop_at_up_q <= 1'b0;
         ramp_req_q <= 1'b0;
         ramp_tgt_q <= 1'b0;
         ramp_cyc_q <= 24'h000001;
         pd_req_q <= 1'b0;
         repeat_en <= 4'h0;
         ch_volume_level <= {4{spc_pkg::VOL_RST}};
         silence_length <= 8'h00;
         monitor_time_sel <= 3'h0;
         thermal_detect_sel <= 2'h0;
         supply_detect_sel <= 3'h0;
         stat_word_q <= 8'h00;
         status_sel_busy_q <= 1'b0;
         status_idx_q <= 2'h0;
      end
      else if (dec)
      begin
         ramp_req_q <= 1'b0;
         pd_req_q <= 1'b0;
         if (first_have_q[0])
         begin
            first_have_q <= 1'b0;
            if (first_q[7:2] == spc_pkg::OPC_ANALOG)
            begin
               highpass_sel <= first_q[1:0];
               dac_gain <= cmd[spc_pkg::DAG_POS +: 2];
               analog_in_gain <= cmd[spc_pkg::AIG_POS +: 2];
               dac_power_enable <= cmd[spc_pkg::DAC_POWER_ENABLE_POS];
               speaker_power_enable <= cmd[spc_pkg::SPEAKER_POWER_ENABLE_POS];
               pop_suppress <= cmd[spc_pkg::POP_POS];
               if (new_on != ana_on_q)
               begin
                  ramp_req_q <= 1'b1;
                  ramp_tgt_q <= new_on;
                  if (new_on)
                     pop_at_up_q <= cmd[spc_pkg::POP_POS];
                  case ({new_on, cmd[spc_pkg::POP_POS]})
                     2'b11: ramp_cyc_q <= UP_POP_CYC;
                     2'b10: ramp_cyc_q <= UP_NOPOP_CYC;
                     2'b01: ramp_cyc_q <= DN_POP_CYC;
                     default: ramp_cyc_q <= DN_NOPOP_CYC;
                  endcase
               end
            end
            else if (first_q[7:4] == spc_pkg::OPC_SILENCE)
            begin
               silence_length <= cmd;
               silence_load <= msk;
            end
            else if (first_q[7:4] == spc_pkg::OPC_CH_VOL)
            begin
               for (int i = 0; i < 4; i++)
                  if (msk[i])
                     ch_volume_level[i*5 +: 5] <= cmd[4:0];
            end
            else if (first_q == spc_pkg::OPC_SAFE)
            begin
               monitor_time_sel <= cmd[7:5];
               thermal_detect_sel <= cmd[4:3];
               supply_detect_sel <= cmd[2:0];
            end
         end
         else if (two_byte(cmd))
         begin
            first_have_q <= 1'b1;
            first_q <= cmd;
         end
         else if (cmd == spc_pkg::OPC_PWR_DOWN)
         begin
            pd_req_q <= 1'b1;
            if (ana_on_q)
            begin
               ramp_req_q <= 1'b1;
               ramp_tgt_q <= 1'b0;
               ramp_cyc_q <= pop_at_up_q ? DN_POP_CYC : DN_NOPOP_CYC;
            end
         end
         else if (cmd == spc_pkg::OPC_ERR_CLR)
            error_clear <= 1'b1;
         else if (cmd[7:4] == spc_pkg::OPC_RPT_SET)
            repeat_en <= repeat_en | cmd[3:0];
         else if (cmd[7:4] == spc_pkg::OPC_RPT_CLR || cmd[7:4] == spc_pkg::OPC_STOP)
            repeat_en <= repeat_en & ~cmd[3:0];
         else if (cmd[7:1] == spc_pkg::OPC_STAT_RD)
            stat_word_q <= cmd[0] ? {5'h00, fault_latched} : {ch_busy, channel_accept_ready};
         else if (cmd[7:3] == spc_pkg::OPC_STAT_PIN)
         begin
            status_sel_busy_q <= cmd[spc_pkg::STAT_SEL_POS];
            status_idx_q <= cmd[1:0];
         end
      end
   end

   // Status pin follows the selected channel continuously.

   always_ff @(posedge sys_clk)
   begin
      if (reset)
         status_pin <= 1'b0;
      else
         status_pin <= status_sel_busy_q ? ch_busy[status_idx_q]
                                         : channel_accept_ready[status_idx_q];
   end

   // Faults are sticky; a new fault in the clearing cycle survives.
   always_ff @(posedge sys_clk)
   begin
      if (reset || pin_low)
         fault_latched <= 3'h0;
      else
         fault_latched <= (error_clear ? 3'h0 : fault_latched) | fault_in;
   end

   // Speaker enable forces the DAC on; otherwise the line output follows it.
   always_ff @(posedge sys_clk)
   begin
      if (init)
      begin
         analog_up <= 1'b0;
         dac_on <= 1'b0;
         speaker_on <= 1'b0;
         line_out_on <= 1'b0;
      end
      else
      begin
         analog_up <= ana_on_q;
         dac_on <= ana_on_q && (dac_power_enable || speaker_power_enable);
         speaker_on <= ana_on_q && speaker_power_enable;
         line_out_on <= ana_on_q && !speaker_power_enable && dac_power_enable;
      end
   end

endmodule : spc_ctrl

// ---- verif/spc_host.sv ----
// Host model that clocks command bytes into the decoder and status bytes out.
// Assumes the link clock idles high and runs only inside a frame.
`timescale 1ns/1ps
module spc_host (
   // Serial command link
   output logic cmd_sclk,
   output logic cmd_sel_n,
   output logic cmd_sdi,
   input wire logic cmd_sdo,
   input wire logic cmd_busy_n
);
   initial
   begin
      cmd_sclk = 1'b1;
      cmd_sel_n = 1'b1;
      cmd_sdi = 1'b0;
   end

   task automatic wt;
      for (int w = 0; w < 20000 && cmd_busy_n !== 1'b1; w++)
         #20;
   endtask : wt

   task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
      wt();
      cmd_sel_n = 1'b0;
      for (int i = 7; i >= 0; i--)
      begin
         #62.5 cmd_sclk = 1'b0;
         cmd_sdi = tx[i];
         #62.5 cmd_sclk = 1'b1;
         rx[i] = cmd_sdo;
      end
      #62.5 cmd_sel_n = 1'b1;
      // No pull on the data line, so it must not keep looking valid.
      cmd_sdi = ~cmd_sdi;
      #300 wt();
   endtask : xfer
endmodule : spc_host

// ---- verif/spc_ctrl_checker.sv ----
// Timing and consistency checks on the decoder's ports.
// Assumes one system clock domain with a synchronous active high reset.
`timescale 1ns/1ps
module spc_ctrl_checker #(
   parameter logic [23:0] OSC_CYC = 24'h000014
) (
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic reset_in_n,
   input wire logic [2:0] fault_in,
   input wire logic cmd_busy_n,
   input wire logic power_down,
   input wire logic dac_on,
   input wire logic speaker_on,
   input wire logic line_out_on,
   input wire logic analog_up,
   input wire logic [3:0] silence_load,
   input wire logic error_clear,
   input wire logic [2:0] fault_latched,
   input wire logic [1:0] dac_gain,
   input wire logic [1:0] highpass_sel,
   input wire logic [3:0] repeat_en,
   input wire logic [19:0] ch_volume_level
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (reset);

   logic [23:0] lo_q;

   // Power-up holds busy low for the oscillator wait, every other command for
   // at least the processing time, so the shorter of the two is the floor.
   localparam logic [23:0] MIN_LO = (OSC_CYC < spc_pkg::PROC_CYC) ? OSC_CYC : spc_pkg::PROC_CYC;

   always_ff @(posedge sys_clk)
   begin
      if (reset || cmd_busy_n)
         lo_q <= 24'h000000;
      else
         lo_q <= lo_q + 24'h000001;
   end

   sequence s_down3;
      power_down [*3];
   endsequence

   property p_off;
      s_down3 |-> !dac_on && !speaker_on && !line_out_on;
   endproperty
   a_off: assert property (p_off) else $error("analog output on in power-down");

   property p_dflt;
      $rose(power_down) |-> ##[0:2] (dac_gain == 2'h2 && repeat_en == 4'h0 &&
         ch_volume_level == 20'h00000 && highpass_sel == 2'h0);
   endproperty
   a_dflt: assert property (p_dflt) else $error("settings kept over power-down");

   property p_spk;
      speaker_on |-> dac_on;
   endproperty
   a_spk: assert property (p_spk) else $error("speaker on without dac");

   property p_line;
      line_out_on |-> !speaker_on;
   endproperty
   a_line: assert property (p_line) else $error("line out with speaker on");

   property p_up;
      $rose(analog_up) |-> ##[0:3] cmd_busy_n;
   endproperty
   a_up: assert property (p_up) else $error("busy stays low after ramp");

   property p_sil;
      silence_load != 4'h0 |=> silence_load == 4'h0;
   endproperty
   a_sil: assert property (p_sil) else $error("silence load longer than a cycle");

   property p_eclr;
      error_clear && fault_in == 3'h0 |-> ##[0:1] fault_latched == 3'h0;
   endproperty
   a_eclr: assert property (p_eclr) else $error("faults kept after clear");

   property p_min;
      $rose(cmd_busy_n) |-> lo_q >= MIN_LO;
   endproperty
   a_min: assert property (p_min) else $error("busy low period too short");

   property p_pin;
      $fell(reset_in_n) |-> ##[1:6] power_down;
   endproperty
   a_pin: assert property (p_pin) else $error("reset pin did not power down");

   property p_fault;
      fault_in[0] |-> ##[1:2] fault_latched[0];
   endproperty
   a_fault: assert property (p_fault) else $error("fault not latched");
endmodule : spc_ctrl_checker

bind spc_ctrl spc_ctrl_checker #(.OSC_CYC(OSC_CYC)) u_chk (.sys_clk, .reset, .reset_in_n,
   .fault_in, .cmd_busy_n, .power_down, .dac_on, .speaker_on, .line_out_on, .analog_up,
   .silence_load, .error_clear, .fault_latched, .dac_gain, .highpass_sel, .repeat_en,
   .ch_volume_level);

// ---- verif/tb.sv ----
// Self-checking bench: commands go through the host model, results are read at ports.
// Assumes shortened oscillator and ramp counts so the run stays brief.
`timescale 1ns/1ps
module tb;
   logic sys_clk, reset, reset_in_n, cmd_sclk, cmd_sel_n, cmd_sdi, cmd_sdo, cmd_busy_n;
   logic [3:0] ch_busy, channel_accept_ready, repeat_en, silence_load, sil_seen;
   logic [2:0] fault_in, monitor_time_sel, supply_detect_sel, fault_latched;
   logic [1:0] highpass_sel, dac_gain, analog_in_gain, thermal_detect_sel;
   logic power_down, pop_suppress, analog_up, dac_on, speaker_on, line_out_on;
   logic dac_power_enable, speaker_power_enable;
   logic error_clear, status_pin, ec_seen;
   logic [19:0] ch_volume_level;
   logic [7:0] silence_length, rx;
   int err_count = 0;
   int num_checks = 0;
   int cyc = 0;
   int lo_c = 0;
   int lo_len = 0;

   spc_ctrl #(.OSC_CYC(24'h000014), .UP_NOPOP_CYC(24'h000028), .DN_NOPOP_CYC(24'h000032),
      .UP_POP_CYC(24'h00001e), .DN_POP_CYC(24'h00003c)) dut (.sys_clk, .reset, .reset_in_n,
      .cmd_sclk, .cmd_sel_n, .cmd_sdi, .cmd_sdo, .cmd_busy_n, .ch_busy,
      .channel_accept_ready, .fault_in, .power_down, .highpass_sel, .dac_gain,
      .analog_in_gain, .dac_power_enable, .speaker_power_enable, .pop_suppress,
      .analog_up, .dac_on, .speaker_on, .line_out_on, .repeat_en, .ch_volume_level,
      .silence_length, .silence_load, .monitor_time_sel, .thermal_detect_sel,
      .supply_detect_sel, .fault_latched, .error_clear, .status_pin);

   spc_host host (.cmd_sclk, .cmd_sel_n, .cmd_sdi, .cmd_sdo, .cmd_busy_n);

   initial
   begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end

   task automatic close_out;
      $display("checks %0d errors %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : close_out

   task automatic chk(input string nm, input logic [19:0] exp, input logic [19:0] got);
      num_checks++;
      if (got !== exp)
      begin
         err_count++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk

   // Busy low length is judged with a small margin for the crossing delays.
   task automatic near(input string nm, input int exp);
      chk(nm, 20'h1, 20'(lo_len >= exp - 2 && lo_len <= exp + 4));
   endtask : near

   task automatic snd(input logic [7:0] b);
      host.xfer(b, rx);
      repeat (3) @(negedge sys_clk);
   endtask : snd

   always @(posedge sys_clk)
   begin
      cyc <= cyc + 1;
      sil_seen <= sil_seen | silence_load;
      ec_seen <= ec_seen | error_clear;
      if (cmd_busy_n === 1'b0)
         lo_c <= lo_c + 1;
      else if (lo_c != 0)
      begin
         lo_len <= lo_c;
         lo_c <= 0;
      end
      if (cyc == 60000)
      begin
         err_count++;
         close_out();
      end
   end

   initial
   begin
      reset = 1'b1;
      reset_in_n = 1'b1;
      ch_busy = 4'ha;
      channel_accept_ready = 4'h6;
      fault_in = 3'h0;
      sil_seen = 4'h0;
      ec_seen = 1'b0;
      repeat (8) @(negedge sys_clk);
      reset = 1'b0;
      repeat (8) @(negedge sys_clk);
      chk("pdown", 20'h1, 20'(power_down));
      chk("dgain", 20'h2, 20'(dac_gain));
      snd(8'ha1);
      snd(8'h1f);
      chk("vol", 20'h0, ch_volume_level);
      snd(8'h00);
      chk("pdown", 20'h0, 20'(power_down));
      chk("outs", 20'h0, 20'({dac_on, speaker_on, line_out_on}));
      for (int i = 0; i < 3; i++)
      begin
         snd(8'h04 | 8'(i));
         snd(8'(i << 5 | (2 - i) << 3));
         chk("hpf", 20'(i), 20'(highpass_sel));
         chk("dgain", 20'(i), 20'(dac_gain));
         chk("again", 20'(2 - i), 20'(analog_in_gain));
      end
      snd(8'h07);
      snd(8'h45);
      near("up pop", 530);
      chk("line", 20'hd, 20'({analog_up, line_out_on, speaker_on, pop_suppress}));
      chk("hpf", 20'h3, 20'(highpass_sel));
      snd(8'h04);
      snd(8'h40);
      near("dn", 550);
      chk("up", 20'h0, 20'({analog_up, line_out_on}));
      snd(8'h04);
      snd(8'h42);
      near("up", 540);
      chk("spk", 20'hd, 20'({dac_on, speaker_on, dac_power_enable, speaker_power_enable}));
      snd(8'h04);
      snd(8'h41);
      near("dn pop", 560);
      snd(8'h75);
      snd(8'ha5);
      chk("sil", 20'h5a5, 20'({sil_seen, silence_length}));
      snd(8'h8f);
      chk("rpt", 20'hf, 20'(repeat_en));
      snd(8'h92);
      chk("rpt", 20'hd, 20'(repeat_en));
      snd(8'h64);
      chk("rpt", 20'h9, 20'(repeat_en));
      snd(8'ha9);
      snd(8'hf3);
      chk("vol", 20'h98013, ch_volume_level);
      snd(8'hd0);
      snd(8'hb5);
      chk("safe", 20'hb5, 20'({monitor_time_sel, thermal_detect_sel, supply_detect_sel}));
      fault_in = 3'h5;
      @(negedge sys_clk);
      fault_in = 3'h0;
      repeat (3) @(negedge sys_clk);
      snd(8'hb1);
      snd(8'h00);
      chk("err stat", 20'h05, 20'(rx));
      snd(8'hb0);
      snd(8'h00);
      chk("ch stat", 20'ha6, 20'(rx));
      snd(8'hff);
      chk("clr", 20'h8, 20'({ec_seen, fault_latched}));
      for (int i = 0; i < 4; i++)
      begin
         snd((8'hc4 | 8'(i)) ^ (i[0] ? 8'h04 : 8'h00));
         chk("stpin", 20'(i[0] ? channel_accept_ready[i] : ch_busy[i]), 20'(status_pin));
      end
      snd(8'h20);
      chk("dflt", 20'h180, 20'({power_down, dac_gain, repeat_en, highpass_sel}));
      chk("vol", 20'h0, ch_volume_level);
      snd(8'h8f);
      chk("rpt", 20'h0, 20'(repeat_en));
      snd(8'h01);
      snd(8'h8f);
      snd(8'h8f);
      chk("rpt", 20'hf, 20'(repeat_en));
      snd(8'h91);
      snd(8'h92);
      chk("rpt", 20'hf, 20'(repeat_en));
      reset_in_n = 1'b0;
      repeat (10) @(negedge sys_clk);
      chk("pin", 20'h10, 20'({power_down, repeat_en}));
      reset_in_n = 1'b1;
      close_out();
   end
endmodule : tb
